// ===== rtl/bk3_pkg.sv
package bk3_pkg;

   // =====================================================
   // Register port geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // =====================================================
   // Register offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;      // Mode control bits
   localparam logic [3:0] OFS_STATUS = 4'h1;    // Sense and latched limit
   localparam logic [3:0] OFS_SP_RUN = 4'h2;    // Run setpoint, read only
   localparam logic [3:0] OFS_SP_LOW = 4'h3;    // Sleep high nibble, standby low

   // =====================================================
   // Field positions
   localparam int CTRL_W = 5;                   // Enable is bit 0 up to forced PWM at bit 4
   localparam int STAT_SENSE_BIT = 0;
   localparam int STAT_LATCH_BIT = 1;

   // =====================================================
   // Setpoint scale
   localparam int SETPT_W = 4;
   localparam int MV_W = 12;
   localparam int SETPT_BASE_MV = 1800;
   localparam int SETPT_STEP_MV = 100;

   // =====================================================
   // Debounce timing
   localparam int DEBOUNCE_US = 8000;           // 8.0 ms
   localparam int CLK_KHZ = 40000;              // 40 MHz core clock
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_KHZ / 1000;

   // =====================================================
   // Types
   typedef enum logic [1:0] {
      PWR_DISABLED = 2'h0,
      PWR_RUN = 2'h1,
      PWR_STANDBY = 2'h2,
      PWR_SLEEP = 2'h3
   } bk3_pwr_t;

   typedef enum logic [1:0] {
      MODE_OFF = 2'h0,
      MODE_ADAPTIVE = 2'h1,
      MODE_FPWM = 2'h2,
      MODE_LOWPWR = 2'h3
   } bk3_mode_t;

   // Host control bits, enable in the least significant bit
   typedef struct packed {
      logic forcedPwm;
      logic lowPower;
      logic sleepEnable;
      logic standbyEnable;
      logic enable;
   } bk3_ctrl_t;

   // Drive toward the power stage
   typedef struct packed {
      bk3_mode_t mode;
      logic regEnable;
      logic dischargeEn;
      logic lowBias;
      logic [SETPT_W-1:0] setpointCode;
      logic [MV_W-1:0] setpointMv;
   } bk3_drive_t;

   // Whole state of the control block except the debounce timer
   typedef struct packed {
      bk3_ctrl_t ctrl;
      logic sense;
      logic latched;
      logic [SETPT_W-1:0] spRun;
      logic [SETPT_W-1:0] spStandby;
      logic [SETPT_W-1:0] spSleep;
      bk3_pwr_t prevPwr;
      bk3_drive_t drive;
      logic hsOff;
      logic lsOff;
      logic [DATA_W-1:0] rdData;
   } bk3_state_t;

   // =====================================================
   // Reset values
   localparam bk3_ctrl_t CTRL_RESET = '{forcedPwm: 1'h0, lowPower: 1'h0, sleepEnable: 1'h0,
                                        standbyEnable: 1'h0, enable: 1'h1};
   localparam bk3_drive_t DRIVE_RESET = '{mode: MODE_ADAPTIVE, regEnable: 1'h1, dischargeEn: 1'h0,
                                          lowBias: 1'h0, setpointCode: 4'h0, setpointMv: 12'h708};
   localparam bk3_state_t STATE_RESET = '{ctrl: CTRL_RESET, sense: 1'h0, latched: 1'h0,
                                          spRun: 4'h0, spStandby: 4'h0, spSleep: 4'h0,
                                          prevPwr: PWR_DISABLED, drive: DRIVE_RESET,
                                          hsOff: 1'h0, lsOff: 1'h0, rdData: 8'h00};

endpackage

// ===== rtl/bk3_debounce.sv
`timescale 1ns/1ps
module bk3_debounce
   import bk3_pkg::*;
#(
   parameter int unsigned LIMIT = DEBOUNCE_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Fault sense in, expiry out
   input wire logic senseIn,
   output logic expired
);

   localparam int CW = $clog2(LIMIT + 1);

   // =====================================================
   // Elaboration check
   if (LIMIT < 2) begin : g_bad_limit
      $error("bk3_debounce: LIMIT must be at least 2");
   end

   typedef struct packed {
      logic [CW-1:0] count;   // Cycles the fault has stood
      logic expired;          // Fault held longer than the interval
   } bk3_dbn_t;

   bk3_dbn_t q;
   bk3_dbn_t d;

   // =====================================================
   // Counter; saturates so a long fault keeps expiry high
   always_comb begin
      d = q;
      d.expired = 1'h0;
      if (!senseIn) begin
         d.count = '0;
      end else if (q.count != CW'(LIMIT)) begin
         d.count = q.count + CW'(1);
      end else begin
         // Interval fully elapsed and fault still present: strictly longer
         d.expired = 1'h1;
      end
   end

   // State register
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign expired = q.expired;

   // =====================================================
   // Assertions
   a_debounce_restart: assert property (@(posedge core_clk) disable iff (sys_rst)
      !senseIn |=> q.count == '0)
      else $error("debounce count did not restart");

   a_expiry_late: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(q.expired) |-> $past(q.count) == CW'(LIMIT) && $past(senseIn))
      else $error("expiry before debounce interval");

endmodule

// ===== rtl/bk3_mode_ctrl.sv
`timescale 1ns/1ps
module bk3_mode_ctrl
   import bk3_pkg::*;
#(
   parameter int unsigned DEBOUNCE_LIMIT = DEBOUNCE_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DATA_W-1:0] regRdData,
   // Power state and fused setpoint
   input bk3_pwr_t powerState,
   input wire logic [SETPT_W-1:0] fusedSetpoint,
   // Switch current limit
   input wire logic cycleStart,
   input wire logic hsOverLimit,
   input wire logic lsOverLimit,
   output logic hsGateOff,
   output logic lsGateOff,
   // Fault flags
   output logic limitSense,
   output logic limitStatus,
   // Power stage drive
   output bk3_drive_t drive
);

   // =====================================================
   // Elaboration check
   if (DEBOUNCE_LIMIT < 2) begin : g_bad_limit
      $error("bk3_mode_ctrl: DEBOUNCE_LIMIT must be at least 2");
   end

   // =====================================================
   // Mode decode from host bits and power state
   function automatic bk3_mode_t selectMode(input bk3_ctrl_t c, input bk3_pwr_t p);
      logic on;
      on = 1'h0;
      // Main enable gates every state; standby and sleep need their own bit
      case (p)
         PWR_RUN: on = c.enable;
         PWR_STANDBY: on = c.enable && c.standbyEnable;
         PWR_SLEEP: on = c.enable && c.sleepEnable;
         default: on = 1'h0;
      endcase
      if (!on) begin
         selectMode = MODE_OFF;
      end else if (c.forcedPwm) begin
         selectMode = MODE_FPWM;
      end else if (c.lowPower && p != PWR_RUN) begin
         selectMode = MODE_LOWPWR;
      end else begin
         // Run state never goes low power; light load uses discontinuous conduction
         selectMode = MODE_ADAPTIVE;
      end
   endfunction

   // Setpoint that applies in a power state
   function automatic logic [SETPT_W-1:0] pickSetpoint(input bk3_state_t s, input bk3_pwr_t p);
      case (p)
         PWR_STANDBY: pickSetpoint = s.spStandby;
         PWR_SLEEP: pickSetpoint = s.spSleep;
         default: pickSetpoint = s.spRun;
      endcase
   endfunction

   // Millivolts for a code: linear from 1.80 V
   function automatic logic [MV_W-1:0] codeToMv(input logic [SETPT_W-1:0] code);
      codeToMv = MV_W'(SETPT_BASE_MV + int'(code) * SETPT_STEP_MV);
   endfunction

   // =====================================================
   // State and debounce
   bk3_state_t stateQ;    // Registered state
   bk3_state_t stateD;    // Next state
   logic dbnExpired;      // Fault outlasted the interval

   // Debounce timer on the registered sense bit
   bk3_debounce #(
      .LIMIT(DEBOUNCE_LIMIT)
   ) u_debounce (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .senseIn(stateQ.sense),
      .expired(dbnExpired)
   );

   // =====================================================
   // Next-state logic
   always_comb begin
      stateD = stateQ;
      stateD.rdData = '0;

      // Sense follows either limit with one register stage only
      stateD.sense = hsOverLimit || lsOverLimit;

      // Host writes; setpoint registers ignore writes
      if (regWr) begin
         case (regAddr)
            OFS_CTRL: begin
               stateD.ctrl = bk3_ctrl_t'(regWrData[CTRL_W-1:0]);
            end
            OFS_STATUS: begin
               // Write one to clear the latched limit
               if (regWrData[STAT_LATCH_BIT]) begin
                  stateD.latched = 1'h0;
               end
            end
            default: begin
               // Read-only or unmapped: no effect
            end
         endcase
      end

      // Expiry beats a clear in the same cycle so no event is lost
      if (dbnExpired) begin
         stateD.latched = 1'h1;
      end

      // Host reads: data stand in the next cycle
      if (regRd) begin
         case (regAddr)
            OFS_CTRL: stateD.rdData = DATA_W'(stateQ.ctrl);
            OFS_STATUS: begin
               stateD.rdData[STAT_SENSE_BIT] = stateQ.sense;
               stateD.rdData[STAT_LATCH_BIT] = stateQ.latched;
            end
            OFS_SP_RUN: stateD.rdData = DATA_W'(stateQ.spRun);
            OFS_SP_LOW: stateD.rdData = {stateQ.spSleep, stateQ.spStandby};
            default: stateD.rdData = '0;
         endcase
      end

      // Fused setpoint copied only on start-up into Run; never ramped by the host
      if (stateQ.prevPwr == PWR_DISABLED && powerState == PWR_RUN) begin
         stateD.spRun = fusedSetpoint;
         stateD.spStandby = fusedSetpoint;
         stateD.spSleep = fusedSetpoint;
      end
      stateD.prevPwr = powerState;

      // Mode recomputed every cycle, so writes and state edges both take effect
      stateD.drive.mode = selectMode(stateQ.ctrl, powerState);
      stateD.drive.regEnable = stateD.drive.mode != MODE_OFF;
      stateD.drive.dischargeEn = stateD.drive.mode == MODE_OFF;
      stateD.drive.lowBias = stateD.drive.mode == MODE_LOWPWR;
      // Setpoint steps with power state only; no scaling ramp exists
      stateD.drive.setpointCode = pickSetpoint(stateQ, powerState);
      stateD.drive.setpointMv = codeToMv(stateD.drive.setpointCode);

      // Cycle-by-cycle limit: off for the rest of the cycle, re-armed at the next.
      // A trip in the start cycle wins, since the switch would only trip again.
      if (hsOverLimit) begin
         stateD.hsOff = 1'h1;
      end else if (cycleStart) begin
         stateD.hsOff = 1'h0;
      end
      if (lsOverLimit) begin
         stateD.lsOff = 1'h1;
      end else if (cycleStart) begin
         stateD.lsOff = 1'h0;
      end
   end

   // =====================================================
   // State register
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stateQ <= STATE_RESET;
      end else begin
         stateQ <= stateD;
      end
   end

   // =====================================================
   // Outputs, all straight from the state register
   assign regRdData = stateQ.rdData;
   assign hsGateOff = stateQ.hsOff;
   assign lsGateOff = stateQ.lsOff;
   assign limitSense = stateQ.sense;
   assign limitStatus = stateQ.latched;
   assign drive = stateQ.drive;

   // =====================================================
   // Assertions
   a_off_discharge: assert property (@(posedge core_clk) disable iff (sys_rst)
      stateQ.drive.mode == MODE_OFF |-> stateQ.drive.dischargeEn && !stateQ.drive.regEnable)
      else $error("off mode without discharge");

   a_enable_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
      ##1 (!$past(stateQ.ctrl.enable) || ($past(powerState) == PWR_STANDBY && !$past(stateQ.ctrl.standbyEnable))
      || ($past(powerState) == PWR_SLEEP && !$past(stateQ.ctrl.sleepEnable))) |-> !stateQ.drive.regEnable)
      else $error("regulator enabled without its enable bits");

   a_fpwm_override: assert property (@(posedge core_clk) disable iff (sys_rst)
      stateQ.ctrl.forcedPwm && stateQ.ctrl.enable && (powerState == PWR_RUN
      || (powerState == PWR_STANDBY && stateQ.ctrl.standbyEnable)
      || (powerState == PWR_SLEEP && stateQ.ctrl.sleepEnable)) |=> stateQ.drive.mode == MODE_FPWM)
      else $error("forced PWM not selected");

   a_run_no_lowpower: assert property (@(posedge core_clk) disable iff (sys_rst)
      powerState == PWR_RUN |=> stateQ.drive.mode != MODE_LOWPWR && !stateQ.drive.lowBias)
      else $error("low power selected in run state");

   a_standby_lowpower: assert property (@(posedge core_clk) disable iff (sys_rst)
      powerState == PWR_STANDBY && stateQ.ctrl.enable && stateQ.ctrl.standbyEnable && stateQ.ctrl.lowPower
      && !stateQ.ctrl.forcedPwm |=> stateQ.drive.mode == MODE_LOWPWR && stateQ.drive.lowBias)
      else $error("standby low power not selected");

   a_sleep_lowpower: assert property (@(posedge core_clk) disable iff (sys_rst)
      powerState == PWR_SLEEP && stateQ.ctrl.enable && stateQ.ctrl.sleepEnable && stateQ.ctrl.lowPower
      && !stateQ.ctrl.forcedPwm |=> stateQ.drive.mode == MODE_LOWPWR)
      else $error("sleep low power not selected");

   a_write_reevaluates: assert property (@(posedge core_clk) disable iff (sys_rst)
      regWr && regAddr == OFS_CTRL && regWrData[CTRL_W-1:0] == 5'h00 |=> ##1 stateQ.drive.mode == MODE_OFF)
      else $error("control write did not change mode");

   a_limit_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      hsOverLimit || (hsGateOff && !cycleStart) |=> hsGateOff)
      else $error("high side switch re-armed inside the cycle");

   a_low_limit_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      lsOverLimit || (lsGateOff && !cycleStart) |=> lsGateOff)
      else $error("low side switch re-armed inside the cycle");

   // Without this the gates could stick off forever and the hold checks would still pass
   a_limit_rearm: assert property (@(posedge core_clk) disable iff (sys_rst)
      cycleStart && !hsOverLimit && !lsOverLimit |=> !hsGateOff && !lsGateOff)
      else $error("switch not re-armed at cycle start");

   a_sense_immediate: assert property (@(posedge core_clk) disable iff (sys_rst)
      (hsOverLimit || lsOverLimit) |=> limitSense)
      else $error("sense bit late");

   a_status_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
      limitStatus && !(regWr && regAddr == OFS_STATUS && regWrData[STAT_LATCH_BIT]) |=> limitStatus)
      else $error("latched status dropped without clear");

   a_setpoint_fixed: assert property (@(posedge core_clk) disable iff (sys_rst)
      stateQ.prevPwr != PWR_DISABLED |=> $stable(stateQ.spRun) && $stable(stateQ.spSleep))
      else $error("setpoint changed while running");

   a_fused_load: assert property (@(posedge core_clk) disable iff (sys_rst)
      stateQ.prevPwr == PWR_DISABLED && powerState == PWR_RUN |=> stateQ.spStandby == $past(fusedSetpoint))
      else $error("fused setpoint not copied");

   a_setpoint_volts: assert property (@(posedge core_clk) disable iff (sys_rst)
      ##1 $past(powerState) == PWR_RUN |-> stateQ.drive.setpointMv == MV_W'(SETPT_BASE_MV
      + int'($past(stateQ.spRun)) * SETPT_STEP_MV))
      else $error("setpoint millivolts wrong");

endmodule

// ===== bench/bk3_stage_model.sv
`timescale 1ns/1ps
module bk3_stage_model
   import bk3_pkg::*;
#(
   parameter int PERIOD = 10
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Fault requests from the bench
   input wire logic hsFault,
   input wire logic lsFault,
   // Stage signals toward the block
   output logic cycleStart,
   output logic hsOverLimit,
   output logic lsOverLimit
);
   // =====================================================
   // Switching cycle timer
   logic [7:0] phase_q; // Position inside the switching cycle

   // One start pulse per switching period, as a real oscillator gives
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         phase_q <= 8'h00;
         cycleStart <= 1'b0;
      end else begin
         phase_q <= (phase_q == 8'(PERIOD - 1)) ? 8'h00 : phase_q + 8'h01;
         cycleStart <= (phase_q == 8'h00);
      end
   end

   // =====================================================
   // Current comparators
   // A hard fault keeps the comparator tripped, even with the switch off
   assign hsOverLimit = hsFault;
   assign lsOverLimit = lsFault;
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
   import bk3_pkg::*;
   // =====================================================
   // Signals
   localparam int LIMIT = 8; // Short debounce for simulation
   logic core_clk, sys_rst; // Clock and reset
   logic [3:0] regAddr; // Register port
   logic [7:0] regWrData, regRdData, rdVal;
   logic regWr, regRd;
   bk3_pwr_t powerState; // Power state
   logic [3:0] fusedSetpoint;
   logic cycleStart, hsOverLimit, lsOverLimit, hsFault, lsFault;
   logic hsGateOff, lsGateOff, limitSense, limitStatus;
   bk3_drive_t drive;
   int nChecks, nMismatch;

   // =====================================================
   // Instances
   bk3_mode_ctrl #(.DEBOUNCE_LIMIT(LIMIT)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .powerState(powerState), .fusedSetpoint(fusedSetpoint), .cycleStart(cycleStart),
      .hsOverLimit(hsOverLimit), .lsOverLimit(lsOverLimit), .hsGateOff(hsGateOff), .lsGateOff(lsGateOff),
      .limitSense(limitSense), .limitStatus(limitStatus), .drive(drive));
   bk3_stage_model #(.PERIOD(10)) stage (.core_clk(core_clk), .sys_rst(sys_rst), .hsFault(hsFault),
      .lsFault(lsFault), .cycleStart(cycleStart), .hsOverLimit(hsOverLimit), .lsOverLimit(lsOverLimit));

   // 40 MHz clock
   always #12.5 core_clk = ~core_clk;

   // =====================================================
   // Shared tasks
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      nChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", nChecks, nMismatch);
      if (nMismatch == 0 && nChecks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Strobes last one cycle; a gap follows since the next call waits an edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1;
      d = regRdData;
   endtask

   // Settle one edge, then look
   task automatic step();
      @(posedge core_clk);
      #1;
   endtask

   // Mode the table asks for
   function automatic bk3_mode_t expMode(input bk3_pwr_t p, input bk3_ctrl_t c);
      logic on;
      on = c.enable && (p == PWR_RUN || (p == PWR_STANDBY && c.standbyEnable) ||
         (p == PWR_SLEEP && c.sleepEnable));
      if (!on) return MODE_OFF;
      if (c.forcedPwm) return MODE_FPWM;
      if (c.lowPower && p != PWR_RUN) return MODE_LOWPWR;
      return MODE_ADAPTIVE;
   endfunction

   task automatic chkDrive(input bk3_mode_t m);
      chk("mode", 12'(m), 12'(drive.mode));
      chk("regEnable", 12'(m != MODE_OFF), 12'(drive.regEnable));
      chk("dischargeEn", 12'(m == MODE_OFF), 12'(drive.dischargeEn));
      chk("lowBias", 12'(m == MODE_LOWPWR), 12'(drive.lowBias));
   endtask

   // =====================================================
   // Scenarios
   // Values held while reset is still asserted
   task automatic testReset();
      chkDrive(MODE_ADAPTIVE);
      chk("resetMv", 12'h708, drive.setpointMv);
      chk("resetStatus", 12'h000, 12'(limitStatus));
   endtask

   // Control readback and an unmapped hole
   task automatic testRegs();
      rd(OFS_CTRL, rdVal);
      chk("ctrlReset", 12'h001, 12'(rdVal));
      rd(4'hf, rdVal);
      chk("unmapped", 12'h000, 12'(rdVal));
   endtask

   // Every fused code loaded on entry to run; writes and later fuse changes ignored
   task automatic testSetpoint();
      for (int k = 0; k < 16; k++) begin
         @(posedge core_clk);
         powerState <= PWR_DISABLED;
         fusedSetpoint <= 4'(k);
         repeat (2) @(posedge core_clk);
         powerState <= PWR_RUN;
         repeat (3) @(posedge core_clk);
         fusedSetpoint <= ~4'(k);
         repeat (3) step();
         chk("setpointCode", 12'(k), 12'(drive.setpointCode));
         chk("setpointMv", 12'(1800 + 100 * k), drive.setpointMv);
         rd(OFS_SP_LOW, rdVal);
         chk("spLow", 12'({4'(k), 4'(k)}), 12'(rdVal));
         wr(OFS_SP_RUN, 8'hff);
         repeat (2) step();
         chk("spHeld", 12'(k), 12'(drive.setpointCode));
      end
   endtask

   // All control codes in all power states, then state changes alone
   task automatic testModes();
      bk3_pwr_t pw[4] = '{PWR_RUN, PWR_STANDBY, PWR_SLEEP, PWR_DISABLED};
      foreach (pw[i]) begin
         @(posedge core_clk);
         powerState <= pw[i];
         for (int c = 0; c < 32; c++) begin
            wr(OFS_CTRL, 8'(c));
            step();
            chkDrive(expMode(pw[i], bk3_ctrl_t'(c)));
            rd(OFS_CTRL, rdVal);
            chk("ctrlRead", 12'(c), 12'(rdVal));
         end
      end
      // Standby and low power but no sleep enable
      wr(OFS_CTRL, 8'h0b);
      powerState <= PWR_RUN;
      repeat (3) step();
      chkDrive(MODE_ADAPTIVE);
      @(posedge core_clk);
      powerState <= PWR_STANDBY;
      step();
      chkDrive(MODE_LOWPWR);
      @(posedge core_clk);
      powerState <= PWR_SLEEP;
      step();
      chkDrive(MODE_OFF);
   endtask

   // Wait for the next cycle start, bounded
   task automatic waitStart();
      int i;
      for (i = 0; i < 40 && cycleStart !== 1'b1; i++) step();
      if (i == 40) begin
         nMismatch++;
         giveVerdict();
      end
   endtask

   // One-cycle trip on each switch; gate stays off to the cycle's end
   task automatic testLimit();
      for (int s = 0; s < 2; s++) begin
         @(posedge core_clk);
         hsFault <= (s == 0);
         lsFault <= (s == 1);
         @(posedge core_clk);
         hsFault <= 1'b0;
         lsFault <= 1'b0;
         #1;
         chk("hsGateOff", 12'(s == 0), 12'(hsGateOff));
         chk("lsGateOff", 12'(s == 1), 12'(lsGateOff));
         chk("limitSense", 12'h001, 12'(limitSense));
         waitStart();
         chk("gateHeld", 12'h001, 12'(hsGateOff | lsGateOff));
         step();
         chk("gateFree", 12'h000, 12'(hsGateOff | lsGateOff));
         chk("senseDrop", 12'h000, 12'(limitSense));
      end
   endtask

   // Short bursts restart the timer; a long one latches until cleared
   task automatic testDebounce();
      repeat (2) begin
         @(posedge core_clk);
         hsFault <= 1'b1;
         repeat (6) @(posedge core_clk);
         hsFault <= 1'b0;
         repeat (4) step();
      end
      chk("burstStatus", 12'h000, 12'(limitStatus));
      @(posedge core_clk);
      hsFault <= 1'b1;
      // Sense stands from the next edge; status follows LIMIT + 2 edges after that
      repeat (LIMIT + 2) step();
      chk("earlyStatus", 12'h000, 12'(limitStatus));
      step();
      chk("lateStatus", 12'h001, 12'(limitStatus));
      @(posedge core_clk);
      hsFault <= 1'b0;
      repeat (5) step();
      chk("stickyStatus", 12'h001, 12'(limitStatus));
      rd(OFS_STATUS, rdVal);
      chk("statusReg", 12'h002, 12'(rdVal));
      wr(OFS_STATUS, 8'h02);
      step();
      chk("clearedStatus", 12'h000, 12'(limitStatus));
   endtask

   // =====================================================
   // Main sequence
   initial begin
      core_clk = 1'b0;
      sys_rst = 1'b1;
      regAddr = 4'h0;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      powerState = PWR_RUN;
      fusedSetpoint = 4'h0;
      hsFault = 1'b0;
      lsFault = 1'b0;
      nChecks = 0;
      nMismatch = 0;
      repeat (2) step();
      testReset();
      @(posedge core_clk);
      sys_rst <= 1'b0;
      testRegs();
      testSetpoint();
      testModes();
      testLimit();
      testDebounce();
      giveVerdict();
   end
endmodule
